// ===== hw/cie_core.sv
// Purpose: executes AND, CALL, COMPARE, interrupt on/off and FETCH
// Assumes: program memory returns the word one cycle after the address
// Notes: registers, scratchpad and run control reached over AXI4-Lite
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cie_core (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic [cie_pkg::IW-1:0] I_INSTR_DATA,
    output logic [cie_pkg::PC_W-1:0] O_INSTR_ADDR,
    input wire logic I_IRQ,
    output logic O_IRQ_ACK,
    input wire logic [cie_pkg::AXI_AW-1:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [cie_pkg::AXI_AW-1:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY
);
    import cie_pkg::*;

    typedef struct packed {
        cie_state_t state;
        logic [PC_W-1:0] pc;
        logic zero;
        logic carry;
        logic irq_accept_flag;
        logic irq_ack;
        logic [NREG-1:0][DW-1:0] regs;
        logic run;
        logic [RIX_W-1:0] reg_sel;
        logic [SCR_AW-1:0] scr_sel;
        logic aw_full;
        logic [AXI_AW-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cie_core_t;

    cie_core_t s_reg;
    cie_core_t s_next;
    logic [OP_W-1:0] op;
    logic [RIX_W-1:0] dst_idx;
    logic [DW-1:0] dest_register;
    logic [DW-1:0] second_register_operand;
    logic [DW-1:0] immediate_byte;
    logic [DW-1:0] opnd;
    logic [DW-1:0] and_res;
    logic [PC_W-1:0] target;
    logic call_take;
    logic ex;
    logic push;
    logic [PC_W-1:0] stack_top;
    logic [STK_PW-1:0] stack_depth;
    logic [DW-1:0] scr_rd_a;
    logic [DW-1:0] scr_rd_b;
    logic scr_we;
    logic [SCR_AW-1:0] scr_waddr;
    logic [DW-1:0] scr_wdata;
    logic axi_reg_we;
    logic wr_fire;
    logic [31:0] wv;

    // =====================================
    // helper functions
    function automatic logic cond_true(input logic [1:0] c, input logic z, input logic cy);
        logic r;
        r = 1'b0;
        case (c)
            CND_Z: r = z;
            CND_WHEN_ZERO_CLEAR: r = !z;
            CND_C: r = cy;
            CND_NC: r = !cy;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_REGACC)
            || (a == OFF_SCRACC) || (a == OFF_STACK);
    endfunction

    function automatic logic [31:0] read_word(input logic [AXI_AW-1:0] a);
        logic [31:0] r;
        r = 32'h0;
        if (a == OFF_CTRL) begin
            r[CTRL_RUN_BIT] = s_reg.run;
        end else if (a == OFF_STATUS) begin
            r[PC_W-1:0] = s_reg.pc;
            r[ST_ZERO_BIT] = s_reg.zero;
            r[ST_CARRY_BIT] = s_reg.carry;
            r[ST_ACCEPT_BIT] = s_reg.irq_accept_flag;
            r[ST_DEPTH_LO +: STK_PW] = stack_depth;
        end else if (a == OFF_REGACC) begin
            r[ACC_SEL_LO +: RIX_W] = s_reg.reg_sel;
            r[DW-1:0] = s_reg.regs[s_reg.reg_sel];
        end else if (a == OFF_SCRACC) begin
            r[ACC_SEL_LO +: SCR_AW] = s_reg.scr_sel;
            r[DW-1:0] = scr_rd_b;
        end else if (a == OFF_STACK) begin
            r[PC_W-1:0] = stack_top;
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // =====================================
    // instruction field decode
    assign op = I_INSTR_DATA[OP_LO +: OP_W];
    assign dst_idx = I_INSTR_DATA[DST_LO +: RIX_W];
    assign dest_register = s_reg.regs[dst_idx];
    assign second_register_operand = s_reg.regs[I_INSTR_DATA[SRC_LO +: RIX_W]];
    assign immediate_byte = I_INSTR_DATA[IMM_LO +: DW];
    // odd opcodes take the second register, even ones the immediate
    assign opnd = op[0] ? second_register_operand : immediate_byte;
    assign and_res = dest_register & opnd;
    assign target = I_INSTR_DATA[ADR_LO +: PC_W];
    assign call_take = (op == OP_CALL) || ((op == OP_CALL_CND) && cond_true(I_INSTR_DATA[COND_LO +: 2],
        s_reg.zero, s_reg.carry));
    assign ex = (s_reg.state == ST_EXEC);

    // =====================================
    // next state: bus slave and execution
    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        scr_we = 1'b0;
        axi_reg_we = 1'b0;
        wv = merge(read_word(s_reg.aw_addr), s_reg.w_data, s_reg.w_strb);
        scr_waddr = wv[ACC_SEL_LO +: SCR_AW];
        scr_wdata = wv[DW-1:0];
        wr_fire = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
        // write address and data taken in either order
        if (I_AXI_AWVALID && s_reg.aw_rdy) begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && s_reg.w_rdy) begin
            s_next.w_full = 1'b1;
            s_next.w_data = I_AXI_WDATA;
            s_next.w_strb = I_AXI_WSTRB;
        end
        if (s_reg.bvalid && I_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
        end
        // commit a write once both halves are held
        if (wr_fire) begin
            s_next.aw_full = 1'b0;
            s_next.w_full = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = is_mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s_reg.aw_addr == OFF_CTRL) begin
                s_next.run = wv[CTRL_RUN_BIT];
            end else if (s_reg.aw_addr == OFF_REGACC) begin
                s_next.reg_sel = wv[ACC_SEL_LO +: RIX_W];
                if (wv[ACC_WE_BIT]) begin
                    s_next.regs[wv[ACC_SEL_LO +: RIX_W]] = wv[DW-1:0];
                    axi_reg_we = 1'b1;
                end
            end else if (s_reg.aw_addr == OFF_SCRACC) begin
                s_next.scr_sel = scr_waddr;
                scr_we = wv[ACC_WE_BIT];
            end
        end
        // read path
        if (s_reg.rvalid && I_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
        end
        if (I_AXI_ARVALID && s_reg.ar_rdy) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = is_mapped(I_AXI_ARADDR) ? read_word(I_AXI_ARADDR) : 32'h0;
            s_next.rresp = is_mapped(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        s_next.aw_rdy = !s_next.aw_full && !s_next.bvalid;
        s_next.w_rdy = !s_next.w_full && !s_next.bvalid;
        s_next.ar_rdy = !s_next.rvalid;
        s_next.irq_ack = 1'b0;
        case (s_reg.state)
            ST_FETCH: begin
                if (s_reg.run) begin
                    if (s_reg.irq_accept_flag && I_IRQ) begin
                        s_next.state = ST_IRQ;
                        s_next.irq_ack = 1'b1;
                    end else begin
                        s_next.state = ST_EXEC;
                    end
                end
            end
            ST_IRQ: begin
                push = 1'b1;
                s_next.pc = IRQ_VECTOR;
                s_next.irq_accept_flag = 1'b0;
                s_next.state = ST_FETCH;
            end
            ST_EXEC: begin
                s_next.state = ST_FETCH;
                s_next.pc = PC_W'(s_reg.pc + 1'b1);
                case (op)
                    OP_AND_IMM, OP_AND_REG: begin
                        s_next.regs[dst_idx] = and_res;
                        s_next.zero = (and_res == '0);
                        s_next.carry = 1'b0;
                    end
                    OP_CMP_IMM, OP_CMP_REG: begin
                        s_next.zero = (opnd == dest_register);
                        s_next.carry = (opnd > dest_register);
                    end
                    OP_FET_IMM, OP_FET_REG: begin
                        s_next.regs[dst_idx] = scr_rd_a;
                    end
                    OP_CALL, OP_CALL_CND: begin
                        if (call_take) begin
                            push = 1'b1;
                            s_next.pc = target;
                        end
                    end
                    OP_INT_DIS: s_next.irq_accept_flag = 1'b0;
                    OP_INT_EN: s_next.irq_accept_flag = 1'b1;
                    default: s_next.pc = PC_W'(s_reg.pc + 1'b1);
                endcase
            end
            default: s_next.state = ST_FETCH;
        endcase
    end

    // state register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            s_reg <= '0;
            s_reg.pc <= PC_RESET;
            s_reg.run <= CTRL_RUN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // =====================================
    // storage instances
    // return stack
    cie_call_stack #(.DEPTH(STK_DEPTH), .AW(PC_W), .PW(STK_PW)) u_stack (
        .i_clk(I_CLOCK),
        .i_rst_b(I_RST_B),
        .i_push(push),
        .i_data(s_reg.pc),
        .o_top(stack_top),
        .o_depth(stack_depth)
    );
    cie_scratchpad #(.DEPTH(SCR_DEPTH), .AW(SCR_AW), .DW(DW)) u_scr (
        .i_clk(I_CLOCK),
        .i_rst_b(I_RST_B),
        .i_we(scr_we),
        .i_waddr(scr_waddr),
        .i_wdata(scr_wdata),
        .i_raddr_a(opnd[SCR_AW-1:0]),
        .o_rdata_a(scr_rd_a),
        .i_raddr_b(s_reg.scr_sel),
        .o_rdata_b(scr_rd_b)
    );

    // outputs from flops
    assign O_INSTR_ADDR = s_reg.pc;
    assign O_IRQ_ACK = s_reg.irq_ack;
    assign O_AXI_AWREADY = s_reg.aw_rdy;
    assign O_AXI_WREADY = s_reg.w_rdy;
    assign O_AXI_BVALID = s_reg.bvalid;
    assign O_AXI_BRESP = s_reg.bresp;
    assign O_AXI_ARREADY = s_reg.ar_rdy;
    assign O_AXI_RVALID = s_reg.rvalid;
    assign O_AXI_RDATA = s_reg.rdata;
    assign O_AXI_RRESP = s_reg.rresp;

    // =====================================
    // checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    logic is_and;
    logic is_cmp;
    logic is_call;
    logic is_fet;
    assign is_and = ex && ((op == OP_AND_IMM) || (op == OP_AND_REG));
    assign is_cmp = ex && ((op == OP_CMP_IMM) || (op == OP_CMP_REG));
    assign is_call = ex && ((op == OP_CALL) || (op == OP_CALL_CND));
    assign is_fet = ex && ((op == OP_FET_IMM) || (op == OP_FET_REG));
    sequence seq_slot;
        (s_reg.state == ST_FETCH) && s_reg.run && !(s_reg.irq_accept_flag && I_IRQ) ##1 ex;
    endsequence
    sequence seq_irq;
        (s_reg.state == ST_FETCH) && s_reg.run && s_reg.irq_accept_flag && I_IRQ
            ##1 (s_reg.state == ST_IRQ) && O_IRQ_ACK;
    endsequence
    AST_AND_RES: assert property (is_and && !axi_reg_we |=>
        s_reg.regs[$past(dst_idx)] == ($past(dest_register) & $past(opnd)))
        else $error("and result not written back");
    AST_AND_ZERO: assert property (is_and |=> s_reg.zero == ($past(and_res) == 8'h00))
        else $error("and zero flag wrong");
    AST_AND_CARRY: assert property (is_and |=> !s_reg.carry)
        else $error("and left carry set");
    AST_CALL_TAKE: assert property (is_call && call_take |=>
        (s_reg.pc == $past(target)) && (stack_top == $past(s_reg.pc)))
        else $error("taken call wrong pc or stack");
    AST_CALL_SKIP: assert property (is_call && !call_take |=>
        (s_reg.pc == PC_W'($past(s_reg.pc) + 1'b1)) && $stable(stack_depth) && $stable(stack_top))
        else $error("skipped call changed stack or pc");
    AST_CALL_FLAGS: assert property (is_call |=> $stable(s_reg.zero) && $stable(s_reg.carry))
        else $error("call altered flags");
    AST_CMP_FLAGS: assert property (is_cmp |=> (s_reg.zero == ($past(opnd) == $past(dest_register)))
        && (s_reg.carry == ($past(opnd) > $past(dest_register))))
        else $error("compare flags wrong");
    AST_CMP_KEEP: assert property (is_cmp && !axi_reg_we |=> s_reg.regs == $past(s_reg.regs))
        else $error("compare wrote a register");
    AST_INT_DIS: assert property (ex && (op == OP_INT_DIS) |=> !s_reg.irq_accept_flag
        && (s_reg.pc == PC_W'($past(s_reg.pc) + 1'b1)))
        else $error("disable did not clear flag");
    AST_INT_EN: assert property (ex && (op == OP_INT_EN) |=> s_reg.irq_accept_flag
        && (s_reg.pc == PC_W'($past(s_reg.pc) + 1'b1)))
        else $error("enable did not set flag");
    AST_IRQ_VEC: assert property (seq_irq |=> (s_reg.pc == IRQ_VECTOR) && !s_reg.irq_accept_flag)
        else $error("interrupt vector not taken");
    AST_FETCH: assert property (is_fet && !axi_reg_we |=>
        (s_reg.regs[$past(dst_idx)] == $past(scr_rd_a)) && $stable(s_reg.zero) && $stable(s_reg.carry))
        else $error("fetch result or flags wrong");
    AST_SLOT: assert property (seq_slot |-> $stable(s_reg.pc) ##1 (s_reg.state == ST_FETCH))
        else $error("slot not two cycles");
endmodule // cie_core

// ===== pkg/cie_pkg.sv
// Purpose: shared constants for the instruction execution subset
// Assumes: 18-bit instruction words, 32-bit AXI4-Lite data
// Notes: opcode values are a local encoding
package cie_pkg;
    // =====================================
    // sizes
    localparam int PC_W = 10;
    localparam int DW = 8;
    localparam int IW = 18;
    localparam int NREG = 16;
    localparam int RIX_W = 4;
    localparam int STK_DEPTH = 31;
    localparam int STK_PW = 5;
    localparam int SCR_DEPTH = 64;
    localparam int SCR_AW = 6;
    localparam int AXI_AW = 8;
    // =====================================
    // instruction fields
    localparam int OP_LO = 12;
    localparam int OP_W = 6;
    localparam int DST_LO = 8;
    localparam int SRC_LO = 4;
    localparam int IMM_LO = 0;
    localparam int COND_LO = 10;
    localparam int ADR_LO = 0;
    localparam logic [OP_W-1:0] OP_AND_IMM = 6'h0a;
    localparam logic [OP_W-1:0] OP_AND_REG = 6'h0b;
    localparam logic [OP_W-1:0] OP_CMP_IMM = 6'h14;
    localparam logic [OP_W-1:0] OP_CMP_REG = 6'h15;
    localparam logic [OP_W-1:0] OP_FET_IMM = 6'h06;
    localparam logic [OP_W-1:0] OP_FET_REG = 6'h07;
    localparam logic [OP_W-1:0] OP_CALL = 6'h30;
    localparam logic [OP_W-1:0] OP_CALL_CND = 6'h31;
    localparam logic [OP_W-1:0] OP_INT_DIS = 6'h3c;
    localparam logic [OP_W-1:0] OP_INT_EN = 6'h3d;
    localparam logic [1:0] CND_Z = 2'h0;
    localparam logic [1:0] CND_WHEN_ZERO_CLEAR = 2'h1;
    localparam logic [1:0] CND_C = 2'h2;
    localparam logic [1:0] CND_NC = 2'h3;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h3ff;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    // =====================================
    // register map
    localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_REGACC = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_SCRACC = 8'h0c;
    localparam logic [AXI_AW-1:0] OFF_STACK = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_ZERO_BIT = 16;
    localparam int ST_CARRY_BIT = 17;
    localparam int ST_ACCEPT_BIT = 18;
    localparam int ST_DEPTH_LO = 24;
    localparam int ACC_SEL_LO = 8;
    localparam int ACC_WE_BIT = 31;
    localparam logic CTRL_RUN_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_IRQ} cie_state_t;
endpackage

// ===== hw/cie_scratchpad.sv
// Purpose: 64-byte scratchpad, one write port, two read ports
// Assumes: reads are combinational from the array
// Notes: cleared by reset
`timescale 1ns/1ps
module cie_scratchpad #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_a,
    output logic [DW-1:0] o_rdata_a,
    input wire logic [AW-1:0] i_raddr_b,
    output logic [DW-1:0] o_rdata_b
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
    } cie_scr_t;
    cie_scr_t s_reg;
    cie_scr_t s_next;
    // =====================================
    // write and read
    always_comb begin
        s_next = s_reg;
        if (i_we) begin
            s_next.mem[i_waddr] = i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign o_rdata_a = s_reg.mem[i_raddr_a];
    assign o_rdata_b = s_reg.mem[i_raddr_b];
endmodule // cie_scratchpad

// ===== hw/cie_call_stack.sv
// Purpose: circular return-address stack
// Assumes: push only from this block; nothing in this project pops
// Notes: a push past the depth overwrites the oldest entry
`timescale 1ns/1ps
module cie_call_stack #(
    parameter int DEPTH = 31,
    parameter int AW = 10,
    parameter int PW = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_push,
    input wire logic [AW-1:0] i_data,
    output logic [AW-1:0] o_top,
    output logic [PW-1:0] o_depth
);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW-1:0] FULL = PW'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] mem;
        logic [PW-1:0] ptr;
        logic [PW-1:0] depth;
    } cie_stk_t;
    cie_stk_t s_reg;
    cie_stk_t s_next;
    // =====================================
    // push logic
    always_comb begin
        s_next = s_reg;
        if (i_push) begin
            s_next.mem[s_reg.ptr] = i_data;
            s_next.ptr = (s_reg.ptr == LAST) ? '0 : PW'(s_reg.ptr + 1'b1);
            s_next.depth = (s_reg.depth == FULL) ? FULL : PW'(s_reg.depth + 1'b1);
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign o_top = s_reg.mem[(s_reg.ptr == '0) ? LAST : PW'(s_reg.ptr - 1'b1)];
    assign o_depth = s_reg.depth;
    // =====================================
    // checks
    // nesting depth
    AST_STK_DEPTH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_push |=> (o_depth == (($past(o_depth) == FULL) ? FULL : PW'($past(o_depth) + 1'b1)))
            && (o_top == $past(i_data)))
        else $error("stack depth or top wrong after push");
endmodule // cie_call_stack

// ===== tb/cie_prog_mem.sv
// Purpose: program memory model for the core
// Assumes: bench fills mem before the core runs
// Notes: one-cycle read latency, like a block ram
`timescale 1ns/1ps
module cie_prog_mem (
    input wire logic i_clk,
    input wire logic [cie_pkg::PC_W-1:0] i_addr,
    output logic [cie_pkg::IW-1:0] o_data
);
    import cie_pkg::*;
    logic [IW-1:0] mem [1024];
    // empty words hold an unused opcode
    initial begin
        foreach (mem[k]) mem[k] = 18'h3f000;
        o_data = 18'h3f000;
    end
    // registered read of the addressed word
    always @(posedge i_clk) begin
        o_data <= mem[i_addr];
    end
endmodule // cie_prog_mem

// ===== tb/cie_core_tb_top.sv
// Purpose: bench for the execution subset core
// Assumes: register access over AXI4-Lite tasks
// Notes: one program walks every instruction kind
`timescale 1ns/1ps
module cie_core_tb_top;
    import cie_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, irq = 1'b0;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, v;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wr, bv, arr, rv, ack;
    logic [1:0] br, rr, r;
    logic [PC_W-1:0] pc, last_pc = '0;
    logic [IW-1:0] instr;
    logic [PC_W-1:0] trace [$];
    logic [PC_W-1:0] exp_pc [13] = '{10'h001, 10'h002, 10'h010, 10'h011, 10'h012, 10'h013,
        10'h020, 10'h021, 10'h022, 10'h023, 10'h024, 10'h025, 10'h026};
    logic [31:0] init_w [7] = '{32'h8000013c, 32'h800002a5, 32'h8000035a, 32'h800006ff,
        32'h8000070c, 32'h80000577, 32'h80003f99};
    int error_cnt = 0, checks = 0;
    // ==========================================
    // clock, partner and core
    always #12.5 clk = ~clk;
    cie_prog_mem cie_prog_mem_i (.i_clk(clk), .i_addr(pc), .o_data(instr));
    cie_core cie_core_i (.I_CLOCK(clk), .I_RST_B(rst_b), .I_INSTR_DATA(instr), .O_INSTR_ADDR(pc),
        .I_IRQ(irq), .O_IRQ_ACK(ack), .I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr),
        .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wv), .O_AXI_WREADY(wr), .O_AXI_BRESP(br),
        .O_AXI_BVALID(bv), .I_AXI_BREADY(bre), .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdat), .O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(rre));
    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // write: handshakes sampled settled, released at the edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ak, wk, bk;
        logic [1:0] resp;
        awa <= a;
        wd <= d;
        {awv, wv, bre} <= 3'b111;
        do begin
            @(negedge clk);
            ak = awv & awr;
            wk = wv & wr;
            bk = bre & bv;
            resp = br;
            @(posedge clk);
            if (ak) awv <= 1'b0;
            if (wk) wv <= 1'b0;
            if (bk) bre <= 1'b0;
        end while (!bk);
        chk(32'(resp), 32'(er));
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ak, rk;
        ara <= a;
        {arv, rre} <= 2'b11;
        do begin
            @(negedge clk);
            ak = arv & arr;
            rk = rre & rv;
            d = rdat;
            rs = rr;
            @(posedge clk);
            if (ak) arv <= 1'b0;
            if (rk) rre <= 1'b0;
        end while (!rk);
        @(posedge clk);
    endtask
    // select a register or scratch byte, then read it back
    task automatic selchk(input logic [7:0] off, input logic [5:0] sel, input logic [7:0] exp);
        axw(off, 32'(sel) << 8, RESP_OKAY);
        axr(off, v, r);
        chk(32'(v[7:0]), 32'(exp));
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // program counter trace, one entry per change
    always @(negedge clk) begin
        if (pc !== last_pc) begin
            trace.push_back(pc);
            last_pc = pc;
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    // ==========================================
    // main sequence
    initial begin
        // load after the model's own fill, while reset still holds
        repeat (16) @(posedge clk);
        cie_prog_mem_i.mem[10'h000] = {OP_AND_IMM, 4'h1, 8'h0f};
        cie_prog_mem_i.mem[10'h001] = {OP_CMP_IMM, 4'h1, 8'h0d};
        cie_prog_mem_i.mem[10'h002] = {OP_CALL_CND, CND_C, 10'h010};
        cie_prog_mem_i.mem[10'h010] = {OP_CALL_CND, CND_NC, 10'h200};
        cie_prog_mem_i.mem[10'h011] = {OP_AND_REG, 4'h2, 8'h30};
        cie_prog_mem_i.mem[10'h012] = {OP_CALL_CND, CND_WHEN_ZERO_CLEAR, 10'h300};
        cie_prog_mem_i.mem[10'h013] = {OP_CALL_CND, CND_Z, 10'h020};
        cie_prog_mem_i.mem[10'h020] = {OP_FET_IMM, 4'h4, 8'hc5};
        cie_prog_mem_i.mem[10'h021] = {OP_FET_REG, 4'h5, 8'h60};
        cie_prog_mem_i.mem[10'h022] = {OP_CMP_REG, 4'h1, 8'h70};
        cie_prog_mem_i.mem[10'h023] = {OP_INT_EN, 12'h000};
        cie_prog_mem_i.mem[10'h024] = {OP_INT_DIS, 12'h000};
        cie_prog_mem_i.mem[10'h025] = {OP_INT_EN, 12'h000};
        cie_prog_mem_i.mem[10'h026] = {OP_CALL, 2'h0, 10'h026};
        cie_prog_mem_i.mem[10'h3ff] = {OP_CALL, 2'h0, 10'h3ff};
        rst_b <= 1'b1;
        @(posedge clk);
        axr(OFF_STATUS, v, r);
        chk(v, 32'h0);
        axw(8'h40, 32'h1, RESP_SLVERR);
        axr(8'h40, v, r);
        chk({v[29:0], r}, 32'h2);
        for (int k = 0; k < 7; k++) axw(k < 5 ? OFF_REGACC : OFF_SCRACC, init_w[k], RESP_OKAY);
        axw(OFF_CTRL, 32'h1, RESP_OKAY);
        repeat (200) @(posedge clk);
        foreach (exp_pc[k]) chk(32'(trace[k]), 32'(exp_pc[k]));
        // pc 026, zero 1, carry 0, accept 1, depth 31
        axr(OFF_STATUS, v, r);
        chk(v, 32'h1f050026);
        axr(OFF_STACK, v, r);
        chk(v, 32'h026);
        selchk(OFF_REGACC, 6'h1, 8'h0c);
        selchk(OFF_REGACC, 6'h2, 8'h00);
        selchk(OFF_REGACC, 6'h7, 8'h0c);
        selchk(OFF_REGACC, 6'h4, 8'h77);
        selchk(OFF_REGACC, 6'h5, 8'h99);
        irq <= 1'b1;
        for (int k = 0; k < 20 && ack !== 1'b1; k++) @(negedge clk);
        chk(32'(ack), 32'h1);
        @(posedge clk);
        irq <= 1'b0;
        repeat (20) @(posedge clk);
        axr(OFF_STATUS, v, r);
        chk(v, 32'h1f0103ff);
        test_done();
    end
endmodule // cie_core_tb_top
